/* analog_ctrl_pkg.sv */
// shared constants, types and decode functions for the analog control register bank
`default_nettype none
package analog_ctrl_pkg;

  // ----------------------------------------------------------------
  // register indexes (byte address is index times four)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_REGU_CTRL = 16'hFECE;
  localparam logic [15:0] IDX_SUPPLY_VOLT = 16'hFED0;
  localparam logic [15:0] IDX_ANA_PWR   = 16'hFED2;
  localparam logic [15:0] IDX_ANA_DIVG  = 16'hFED3;
  localparam logic [15:0] IDX_BTN_STAT  = 16'hFED4;
  localparam int unsigned IDX_LSB       = 2;
  localparam int unsigned IDX_MSB       = 17;

  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_ZERO      = 16'h0000;
  localparam logic [15:0] MASK_ANA_PWR  = 16'h0FDF;
  localparam logic [15:0] MASK_ANA_DIVG = 16'hFFFF;
  localparam logic [15:0] MASK_REGU_CTL = 16'h0FFF;
  localparam logic [15:0] MASK_REGU_VLT = 16'h7FFF;
  localparam logic [15:0] RD_PAD        = 16'h0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned PWR_DEBUG_TEST = 13;
  localparam int unsigned PWR_SHORT_STAT = 12;
  localparam int unsigned PWR_PROT_DIS   = 11;
  localparam int unsigned PWR_USB_XCVR   = 10;
  localparam int unsigned PWR_LNA        = 9;
  localparam int unsigned PWR_GHZ_OSC    = 8;
  localparam int unsigned PWR_MIC_ONE    = 7;
  localparam int unsigned PWR_MIC_TWO    = 6;
  localparam int unsigned PWR_REF_LEVEL  = 4;
  localparam int unsigned PWR_REF_ENA    = 3;
  localparam int unsigned PWR_ADC_THREE  = 2;
  localparam int unsigned PWR_ADC_TWO    = 1;
  localparam int unsigned PWR_ADC_ONE    = 0;
  localparam int unsigned DG_HS_CLK      = 15;
  localparam int unsigned DG_PAD_BIAS    = 14;
  localparam int unsigned CTL_AD_GATE    = 5;
  localparam int unsigned CTL_FM_GATE    = 4;
  localparam int unsigned CTL_LATCH      = 3;
  localparam int unsigned BTN_FLAG       = 0;

  // ----------------------------------------------------------------
  // gain and divider encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] GAIN_CODE_20DB = 3'h1;
  localparam logic [2:0] GAIN_CODE_17DB = 3'h2;
  localparam logic [2:0] GAIN_CODE_14DB = 3'h4;
  localparam logic [2:0] GAIN_CODE_11DB = 3'h0;
  localparam logic [4:0] GAIN_DB_20     = 5'h14;
  localparam logic [4:0] GAIN_DB_17     = 5'h11;
  localparam logic [4:0] GAIN_DB_14     = 5'h0E;
  localparam logic [4:0] GAIN_DB_11     = 5'h0B;
  localparam logic [1:0] FM_SEL_24      = 2'h3;
  localparam logic [1:0] FM_SEL_20      = 2'h2;
  localparam logic [1:0] FM_SEL_BAD     = 2'h1;
  localparam logic [1:0] FM_SEL_16      = 2'h0;
  localparam logic [4:0] FM_RATIO_24    = 5'h18;
  localparam logic [4:0] FM_RATIO_20    = 5'h14;
  localparam logic [4:0] FM_RATIO_16    = 5'h10;

  // ----------------------------------------------------------------
  // bus encodings and types
  // ----------------------------------------------------------------
  localparam logic       HRESP_OKAY = 1'b0;
  localparam int unsigned HTRANS_ACT = 1;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b10
  } bus_phase_t;

  typedef struct packed {
    logic [4:0] flash_supply_code;
    logic       flash_regulator_shutdown;
    logic       analog_regulator_shutdown;
    logic       io_regulator_shutdown;
    logic       core_regulator_shutdown;
    logic [4:0] analog_supply_code;
    logic [4:0] io_supply_code;
    logic [4:0] core_supply_code;
  } regu_set_t;

  // gain code to dB; undefined codes report the minimum gain
  function automatic logic [4:0] gain_db(input logic [2:0] code);
    case (code)
      GAIN_CODE_20DB: gain_db = GAIN_DB_20;
      GAIN_CODE_17DB: gain_db = GAIN_DB_17;
      GAIN_CODE_14DB: gain_db = GAIN_DB_14;
      default:        gain_db = GAIN_DB_11;
    endcase
  endfunction

  // fm divider select to division ratio; the reserved code divides by 24
  function automatic logic [4:0] fm_ratio(input logic [1:0] sel);
    case (sel)
      FM_SEL_24:  fm_ratio = FM_RATIO_24;
      FM_SEL_20:  fm_ratio = FM_RATIO_20;
      FM_SEL_BAD: fm_ratio = FM_RATIO_24;
      default:    fm_ratio = FM_RATIO_16;
    endcase
  endfunction

endpackage
`default_nettype wire

/* analog_power_regulator_ctrl.sv */
// AHB-Lite register bank for analog power enables, dividers, gains and regulators
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - power enable bits power their modules
// - bits 10,9,8 enable USB, LNA, oscillator
// - bits 7,6 enable microphone amplifiers
// - bit 13 shows debug test, read only
// - bit 12 short status, bit 11 protect off
// - bit 4 reference level, bit 3 power
// - fm divider field picks 24, 20, 16
// - bits 11:10 drive oscillator range dividers
// - bits 3:0 trim oscillator centre frequency
// - bit 15 clock driver, bit 14 bias
// - gain codes decode to 20,17,14,11 dB
// - both gain fields reset to zero
// - voltage register holds three supply codes
// - bits 5,4 stop filter, demodulator clocks
// - latch enable moves codes to regulators
// - bits 2,1,0 shut analog, io, core
// - bits 11:7 flash code, bit 6 off
// - button flag sticks until latch set-cleared
module analog_power_regulator_ctrl (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output var  logic                      hreadyout,
  output var  logic [31:0]               hrdata,
  output var  logic                      hresp,
  input  wire logic                      debug_test_pin,
  input  wire logic                      ground_buf_short_pin,
  input  wire logic                      power_button_pin,
  output var  logic                      adc_one_power,
  output var  logic                      adc_two_power,
  output var  logic                      adc_three_power,
  output var  logic                      reference_power_enable,
  output var  logic                      reference_level_select,
  output var  logic                      mic_amp_one_enable,
  output var  logic                      mic_amp_two_enable,
  output var  logic                      ghz_osc_enable,
  output var  logic                      low_noise_amp_enable,
  output var  logic                      usb_transceiver_enable,
  output var  logic                      ground_buf_protect_disable,
  output var  logic                      usb_hs_clock_driver_enable,
  output var  logic                      usb_pad_bias_enable,
  output var  logic [1:0]                fm_divider_select,
  output var  logic [4:0]                fm_divide_ratio,
  output var  logic [1:0]                osc_range_divider,
  output var  logic [3:0]                osc_centre_trim,
  output var  logic [2:0]                adc_one_gain,
  output var  logic [2:0]                adc_two_gain,
  output var  logic [4:0]                adc_one_gain_db,
  output var  logic [4:0]                adc_two_gain_db,
  output var  logic                      ad_filter_clock_gate,
  output var  logic                      fm_demod_clock_gate,
  output var  analog_ctrl_pkg::regu_set_t regulator_setting,
  output var  logic                      power_button_flag
);
  import analog_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  bus_phase_t  phase_reg;
  bus_phase_t  phase_next;
  logic [15:0] idx_reg;
  logic        accept;
  logic        wr_fire;
  logic [15:0] wdata;
  logic [15:0] rd_mux;
  logic [15:0] ana_pwr_reg;
  logic [15:0] ana_divg_reg;
  logic [15:0] regu_ctrl_reg;
  logic [15:0] supply_volt_reg;
  logic [15:0] ana_pwr_view;
  logic        dbg_s1_reg;
  logic        dbg_s2_reg;
  logic        short_s1_reg;
  logic        short_s2_reg;
  regu_set_t   regu_src;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // a transfer is taken only when the bus is ready; hsize is ignored, words only
  assign accept  = hsel & htrans[HTRANS_ACT] & hready;
  assign wr_fire = (phase_reg == BUS_WRITE) & hready;
  assign wdata   = hwdata[15:0];

  // phase sequencing: writes finish at once, reads take one wait state
  always_comb begin
    phase_next = BUS_IDLE;
    unique case (phase_reg)
      BUS_IDLE, BUS_WRITE: begin
        if (accept) begin
          phase_next = hwrite ? BUS_WRITE : BUS_READ;
        end
      end
      BUS_READ: begin
        phase_next = BUS_IDLE;
      end
      default: begin
        phase_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= BUS_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_reg <= RST_ZERO;
    end else if (accept) begin
      idx_reg <= haddr[IDX_MSB:IDX_LSB];
    end
  end

  // the wait state lets a read see a write that retired on the same edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else if (accept && !hwrite) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // read data, unmapped indexes read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= {RD_PAD, RST_ZERO};
    end else if (phase_reg == BUS_READ) begin
      hrdata <= {RD_PAD, rd_mux};
    end
  end

  // every transfer is answered okay, unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= HRESP_OKAY;
    end else begin
      hresp <= HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // status pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dbg_s1_reg   <= 1'b0;
      dbg_s2_reg   <= 1'b0;
      short_s1_reg <= 1'b0;
      short_s2_reg <= 1'b0;
    end else begin
      dbg_s1_reg   <= debug_test_pin;
      dbg_s2_reg   <= dbg_s1_reg;
      short_s1_reg <= ground_buf_short_pin;
      short_s2_reg <= short_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  // power enables
  // status bits not stored; reserved bits stay zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ana_pwr_reg <= RST_ZERO;
    end else if (wr_fire && idx_reg == IDX_ANA_PWR) begin
      ana_pwr_reg <= wdata & MASK_ANA_PWR;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ana_divg_reg <= RST_ZERO;
    end else if (wr_fire && idx_reg == IDX_ANA_DIVG) begin
      ana_divg_reg <= wdata & MASK_ANA_DIVG;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      regu_ctrl_reg <= RST_ZERO;
    end else if (wr_fire && idx_reg == IDX_REGU_CTRL) begin
      regu_ctrl_reg <= wdata & MASK_REGU_CTL;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      supply_volt_reg <= RST_ZERO;
    end else if (wr_fire && idx_reg == IDX_SUPPLY_VOLT) begin
      supply_volt_reg <= wdata & MASK_REGU_VLT;
    end
  end

  // debug test and short status merged into the readback
  always_comb begin
    ana_pwr_view                 = ana_pwr_reg;
    ana_pwr_view[PWR_DEBUG_TEST] = dbg_s2_reg;
    ana_pwr_view[PWR_SHORT_STAT] = short_s2_reg;
  end

  // read multiplexer
  always_comb begin
    rd_mux = RST_ZERO;
    if (idx_reg == IDX_ANA_PWR) begin
      rd_mux = ana_pwr_view;
    end else if (idx_reg == IDX_ANA_DIVG) begin
      rd_mux = ana_divg_reg;
    end else if (idx_reg == IDX_REGU_CTRL) begin
      rd_mux = regu_ctrl_reg;
    end else if (idx_reg == IDX_SUPPLY_VOLT) begin
      rd_mux = supply_volt_reg;
    end else if (idx_reg == IDX_BTN_STAT) begin
      rd_mux[BTN_FLAG] = power_button_flag;
    end
  end

  // ----------------------------------------------------------------
  // analog enables and selects
  // ----------------------------------------------------------------
  // adc, reference, mic, oscillator, lna, usb and protect enables
  assign adc_one_power          = ana_pwr_reg[PWR_ADC_ONE];
  assign adc_two_power          = ana_pwr_reg[PWR_ADC_TWO];
  assign adc_three_power        = ana_pwr_reg[PWR_ADC_THREE];
  assign reference_power_enable = ana_pwr_reg[PWR_REF_ENA];
  assign reference_level_select = ana_pwr_reg[PWR_REF_LEVEL];
  assign mic_amp_one_enable     = ana_pwr_reg[PWR_MIC_ONE];
  assign mic_amp_two_enable     = ana_pwr_reg[PWR_MIC_TWO];
  assign ghz_osc_enable         = ana_pwr_reg[PWR_GHZ_OSC];
  assign low_noise_amp_enable   = ana_pwr_reg[PWR_LNA];
  assign usb_transceiver_enable = ana_pwr_reg[PWR_USB_XCVR];
  assign ground_buf_protect_disable = ana_pwr_reg[PWR_PROT_DIS];

  assign usb_hs_clock_driver_enable = ana_divg_reg[DG_HS_CLK];
  assign usb_pad_bias_enable        = ana_divg_reg[DG_PAD_BIAS];
  assign fm_divider_select          = ana_divg_reg[13:12];
  assign osc_range_divider          = ana_divg_reg[11:10];
  assign adc_two_gain               = ana_divg_reg[9:7];
  assign adc_one_gain               = ana_divg_reg[6:4];
  assign osc_centre_trim            = ana_divg_reg[3:0];

  // gain in dB and divide ratio; decoded one cycle behind the register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_one_gain_db <= GAIN_DB_11;
      adc_two_gain_db <= GAIN_DB_11;
      fm_divide_ratio <= FM_RATIO_16;
    end else begin
      adc_one_gain_db <= gain_db(ana_divg_reg[6:4]);
      adc_two_gain_db <= gain_db(ana_divg_reg[9:7]);
      fm_divide_ratio <= fm_ratio(ana_divg_reg[13:12]);
    end
  end

  // ----------------------------------------------------------------
  // clock gates and regulators
  // ----------------------------------------------------------------
  // high stops the clock
  assign ad_filter_clock_gate = regu_ctrl_reg[CTL_AD_GATE];
  assign fm_demod_clock_gate  = regu_ctrl_reg[CTL_FM_GATE];

  always_comb begin
    regu_src.flash_supply_code         = regu_ctrl_reg[11:7];
    regu_src.flash_regulator_shutdown  = regu_ctrl_reg[6];
    regu_src.analog_regulator_shutdown = regu_ctrl_reg[2];
    regu_src.io_regulator_shutdown     = regu_ctrl_reg[1];
    regu_src.core_regulator_shutdown   = regu_ctrl_reg[0];
    regu_src.analog_supply_code        = supply_volt_reg[14:10];
    regu_src.io_supply_code            = supply_volt_reg[9:5];
    regu_src.core_supply_code          = supply_volt_reg[4:0];
  end

  regu_latch u_latch (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .latch_en (regu_ctrl_reg[CTL_LATCH]),
    .src      (regu_src),
    .held     (regulator_setting)
  );

  button_flag u_button (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .button_pin        (power_button_pin),
    .latch_en          (regu_ctrl_reg[CTL_LATCH]),
    .power_button_flag (power_button_flag)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_PWR_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_fire && idx_reg == IDX_ANA_PWR |=>
      adc_one_power == $past(hwdata[PWR_ADC_ONE]) &&
      usb_transceiver_enable == $past(hwdata[PWR_USB_XCVR]) &&
      mic_amp_two_enable == $past(hwdata[PWR_MIC_TWO]))
    else $error("power enable did not follow the written value");

  AST_PWR_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    !(wr_fire && idx_reg == IDX_ANA_PWR) |=> $stable(ana_pwr_reg))
    else $error("power enables changed without a write");

  AST_READ_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
    accept && !hwrite |=> !hreadyout ##1 hreadyout && hresp == HRESP_OKAY)
    else $error("read answer not given after one wait state");

  AST_DEBUG_RO: assert property (@(posedge hclk) disable iff (!hresetn)
    phase_reg == BUS_READ && idx_reg == IDX_ANA_PWR |=>
      hrdata[PWR_DEBUG_TEST] == $past(dbg_s2_reg))
    else $error("debug test bit does not show the pin state");

  AST_GAIN_RESET: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> adc_one_gain == GAIN_CODE_11DB && adc_two_gain == GAIN_CODE_11DB)
    else $error("gain fields not at minimum after reset");

  AST_GAIN_DB: assert property (@(posedge hclk) disable iff (!hresetn)
    adc_one_gain == GAIN_CODE_20DB ##1 adc_one_gain == GAIN_CODE_20DB |->
      adc_one_gain_db == GAIN_DB_20)
    else $error("adc one gain code 001 did not decode to 20 dB");

  AST_FM_RATIO: assert property (@(posedge hclk) disable iff (!hresetn)
    fm_divider_select == FM_SEL_20 ##1 fm_divider_select == FM_SEL_20 |->
      fm_divide_ratio == FM_RATIO_20)
    else $error("fm select 10 did not give a ratio of 20");

  AST_CLOCK_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_fire && idx_reg == IDX_REGU_CTRL |=>
      ad_filter_clock_gate == $past(hwdata[CTL_AD_GATE]) &&
      fm_demod_clock_gate == $past(hwdata[CTL_FM_GATE]))
    else $error("clock gate bits did not follow the written value");

endmodule
`default_nettype wire

/* button_flag.sv */
// sticky power button indication, released by a set-then-clear of the latch enable
`timescale 1ns/1ps
`default_nettype none
module button_flag (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic button_pin,
  input  wire logic latch_en,
  output var  logic power_button_flag
);
  import analog_ctrl_pkg::*;

  logic pin_s1_reg;
  logic pin_s2_reg;
  logic latch_prev_reg;
  logic release_pulse;

  // ----------------------------------------------------------------
  // pin synchroniser and release detect
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_reg     <= 1'b0;
      pin_s2_reg     <= 1'b0;
      latch_prev_reg <= 1'b0;
    end else begin
      pin_s1_reg     <= button_pin;
      pin_s2_reg     <= pin_s1_reg;
      latch_prev_reg <= latch_en;
    end
  end

  assign release_pulse = latch_prev_reg & ~latch_en;

  // sticky until release
  // a press in the release cycle wins, so no press is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_button_flag <= 1'b0;
    end else if (pin_s2_reg) begin
      power_button_flag <= 1'b1;
    end else if (release_pulse) begin
      power_button_flag <= 1'b0;
    end
  end

  AST_BTN_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
    power_button_flag && !release_pulse |=> power_button_flag)
    else $error("button flag dropped without a latch enable release");

endmodule
`default_nettype wire

/* regu_latch.sv */
// holding stage that passes regulator codes and shutdowns only while latch enable is high
`timescale 1ns/1ps
`default_nettype none
module regu_latch (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      latch_en,
  input  wire analog_ctrl_pkg::regu_set_t src,
  output var  analog_ctrl_pkg::regu_set_t held
);
  import analog_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // capture stage
  // ----------------------------------------------------------------
  // transfer while enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held <= '0;
    end else if (latch_en) begin
      held <= src;
    end
  end

  AST_LATCH_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    !latch_en |=> $stable(held))
    else $error("regulator outputs moved while latch enable was low");

  AST_LATCH_TAKE: assert property (@(posedge hclk) disable iff (!hresetn)
    latch_en |=> held == $past(src))
    else $error("regulator outputs missed the latched codes");

endmodule
`default_nettype wire

/* test_analog_power_regulator_ctrl.sv */
// self-checking bench for the analog control register bank
`timescale 1ns/1ps
`default_nettype none
module test_analog_power_regulator_ctrl;
  import analog_ctrl_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, dphase = 1'b0;
  logic        dbg = 1'b0, shrt = 1'b0, btn = 1'b0, hreadyout, hresp, pbf;
  logic [1:0]  htrans = 2'h0, fsel, odiv;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d, c, v;
  logic        a1, a2, a3, ren, rlv, m1, m2, ghz, lna, usb, prot, hs, bias, adg, fmg;
  logic [4:0]  fratio, g1db, g2db;
  logic [3:0]  trim;
  logic [2:0]  g1, g2;
  regu_set_t   rset;
  logic [31:0] exp_q[$];
  int          fails = 0, checks_done = 0;
  logic [2:0]  gc[5] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3};
  logic [4:0]  gd[5] = '{GAIN_DB_20, GAIN_DB_17, GAIN_DB_14, GAIN_DB_11, GAIN_DB_11};
  logic [4:0]  fr[4] = '{FM_RATIO_16, FM_RATIO_24, FM_RATIO_20, FM_RATIO_24};

  analog_power_regulator_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .debug_test_pin(dbg),
    .ground_buf_short_pin(shrt), .power_button_pin(btn), .adc_one_power(a1),
    .adc_two_power(a2), .adc_three_power(a3), .reference_power_enable(ren),
    .reference_level_select(rlv), .mic_amp_one_enable(m1), .mic_amp_two_enable(m2),
    .ghz_osc_enable(ghz), .low_noise_amp_enable(lna), .usb_transceiver_enable(usb),
    .ground_buf_protect_disable(prot), .usb_hs_clock_driver_enable(hs),
    .usb_pad_bias_enable(bias), .fm_divider_select(fsel), .fm_divide_ratio(fratio),
    .osc_range_divider(odiv), .osc_centre_trim(trim), .adc_one_gain(g1), .adc_two_gain(g2),
    .adc_one_gain_db(g1db), .adc_two_gain_db(g2db), .ad_filter_clock_gate(adg),
    .fm_demod_clock_gate(fmg), .regulator_setting(rset), .power_button_flag(pbf));

  always #50 hclk = ~hclk;

  // ----------------------------------------------------------------
  // checking, closing and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // bounded wait for hready; a hung bus ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      close_out();
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    haddr <= {14'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    exp_q.push_back(exp);
    xfer(1'b0, idx, 32'h0);
  endtask
  // outputs decoded one cycle after the register are settled here
  task automatic settle();
    @(posedge hclk);
    #1;
  endtask

  // read data is compared at the edge where the data phase completes
  always @(posedge hclk) begin
    if (dphase && hreadyout === 1'b1 && exp_q.size() > 0) check(hrdata, exp_q.pop_front());
    if (dphase && hreadyout === 1'b1) check({31'h0, hresp}, {31'h0, HRESP_OKAY});
    if (hreadyout === 1'b1) dphase <= htrans[1] & ~hwrite;
  end

  initial begin
    void'($urandom(68122));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    check({22'h0, g2db, g1db}, {22'h0, GAIN_DB_11, GAIN_DB_11});
    rd(IDX_REGU_CTRL, 32'h0);
    rd(IDX_SUPPLY_VOLT, 32'h0);
    rd(IDX_ANA_DIVG, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d = $urandom & 32'h3FDF;
      dbg <= i[0];
      shrt <= ~i[0];
      xfer(1'b1, IDX_ANA_PWR, d);
      settle();
      check({prot, usb, lna, ghz, m1, m2, 1'b0, rlv, ren, a3, a2, a1}, d[11:0] & 12'hFDF);
      rd(IDX_ANA_PWR, {18'h0, i[0], ~i[0], d[11:6], 1'b0, d[4:0]});
    end
    for (int i = 0; i < 5; i++) begin
      d = {16'h0, i[0], ~i[0], i[1] | i[0], i[0], ~i[1:0], gc[i], gc[(i + 1) % 5], 4'(i * 3)};
      xfer(1'b1, IDX_ANA_DIVG, d);
      settle();
      check({hs, bias, fsel, odiv, g2, g1, trim}, d[15:0]);
      check({fratio, g2db, g1db}, {fr[i % 4], gd[i], gd[(i + 1) % 5]});
      rd(IDX_ANA_DIVG, d);
    end
    v = $urandom & 32'h7FFF;
    c = $urandom & 32'h0FF7;
    xfer(1'b1, IDX_SUPPLY_VOLT, v);
    xfer(1'b1, IDX_REGU_CTRL, c);
    settle();
    check({7'h0, rset}, 32'h0);
    check({adg, fmg}, c[5:4]);
    xfer(1'b1, IDX_REGU_CTRL, c | 32'h8);
    settle();
    check({7'h0, rset}, {7'h0, c[11:6], c[2:0], v[14:0]});
    rd(IDX_REGU_CTRL, c | 32'h8);
    xfer(1'b1, IDX_REGU_CTRL, c);
    xfer(1'b1, IDX_SUPPLY_VOLT, ~v & 32'h7FFF);
    settle();
    check({7'h0, rset}, {7'h0, c[11:6], c[2:0], v[14:0]});
    rd(IDX_SUPPLY_VOLT, ~v & 32'h7FFF);
    btn <= 1'b1;
    repeat (4) settle();
    btn <= 1'b0;
    repeat (4) settle();
    check({31'h0, pbf}, 32'h1);
    rd(IDX_BTN_STAT, 32'h1);
    xfer(1'b1, IDX_REGU_CTRL, c | 32'h8);
    xfer(1'b1, IDX_REGU_CTRL, c);
    settle();
    check({31'h0, pbf}, 32'h0);
    xfer(1'b1, 16'h0100, 32'hFFFF);
    rd(16'h0100, 32'h0);
    repeat (2) settle();
    check(exp_q.size(), 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
